// ### src/spi_host_slave_with_detect.sv
// host port core: strap detection and SPI slave register access
module spi_host_slave_with_detect (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        strap_i2c,
    input  wire logic        address_select_strap,
    input  wire logic        sda_in,
    input  wire logic        test_port_bit5_in,
    input  wire logic        test_port_bit6_in,
    input  wire logic        test_port_bit7_in,
    output logic             test_port_bit7_out,
    output logic             test_port_bit7_oe,
    output logic [1:0]       host_mode,
    output logic [5:0]       reg_addr,
    output logic [7:0]       reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [7:0]  reg_rdata
);
    shd_pins_if pins ();

    // SPI pins share the sda and test port pins; all come from outside the clock domain
    shd_pin_sync #(
        .STAGES (shd_pkg::SHD_SYNC_STAGES)
    ) u_sync (
        .clk            (clk),
        .reset_n        (reset_n),
        .cs_n_pin       (sda_in),
        .sck_pin        (test_port_bit5_in),
        .mosi_pin       (test_port_bit6_in),
        .strap_i2c_pin  (strap_i2c),
        .strap_addr_pin (address_select_strap),
        .pins           (pins.sync_side)
    );

    shd_pkg::shd_state_type state_ff;
    logic [1:0]             settle_cnt_ff;
    logic [1:0]             mode_ff;
    logic                   sck_prev_ff;
    logic [2:0]             bit_cnt_ff;
    logic [6:0]             rx_ff;
    logic                   first_ff;
    logic                   rw_ff;
    logic [7:0]             tx_ff;
    logic                   rd_wait_ff;
    logic                   reg_rd_ff;
    logic                   reg_wr_ff;
    logic [5:0]             reg_addr_ff;
    logic [7:0]             reg_wdata_ff;
    logic                   miso_ff;
    logic                   miso_oe_ff;

    logic                   active;
    logic                   rise;
    logic                   fall;
    logic                   byte_done;
    logic [7:0]             rx_byte;
    logic                   is_read;

    function automatic shd_pkg::shd_state_type decode_mode(input logic i2c,
                                                           input logic addr_strap);
        if (i2c) begin
            decode_mode = shd_pkg::SHD_ST_I2C;
        end else if (addr_strap) begin
            decode_mode = shd_pkg::SHD_ST_SPI;
        end else begin
            decode_mode = shd_pkg::SHD_ST_UART;
        end
    endfunction

    // straps are read once after the synchroniser has filled, then frozen
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff      <= shd_pkg::SHD_ST_SETTLE;
            settle_cnt_ff <= 2'h0;
        end else begin
            case (state_ff)
                shd_pkg::SHD_ST_SETTLE: begin
                    if (settle_cnt_ff == shd_pkg::SHD_SETTLE_CYCLES) begin
                        state_ff <= decode_mode(pins.strap_i2c, pins.strap_addr); // R1 R2
                    end else begin
                        settle_cnt_ff <= settle_cnt_ff + 2'h1;
                    end
                end
                default: begin
                    state_ff <= state_ff;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_ff <= shd_pkg::SHD_MODE_NONE;
        end else begin
            case (state_ff)
                shd_pkg::SHD_ST_SPI:  mode_ff <= shd_pkg::SHD_MODE_SPI;
                shd_pkg::SHD_ST_UART: mode_ff <= shd_pkg::SHD_MODE_UART;
                shd_pkg::SHD_ST_I2C:  mode_ff <= shd_pkg::SHD_MODE_I2C;
                default:              mode_ff <= shd_pkg::SHD_MODE_NONE;
            endcase
        end
    end

    // sampled edges cap the serial clock at a fraction of clk; see the note on rate
    assign active    = (state_ff == shd_pkg::SHD_ST_SPI) && !pins.cs_n; // R3 R12
    assign rise      = pins.sck && !sck_prev_ff; // R6
    assign fall      = !pins.sck && sck_prev_ff; // R7
    assign byte_done = active && rise && (bit_cnt_ff == shd_pkg::SHD_LAST_BIT);
    assign rx_byte   = {rx_ff, pins.mosi}; // R5
    assign is_read   = rx_byte[shd_pkg::SHD_RW_BIT]; // R10

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sck_prev_ff <= 1'b0;
        end else begin
            sck_prev_ff <= pins.sck;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt_ff <= 3'h0;
            rx_ff      <= 7'h00;
            first_ff   <= 1'b1;
        end else if (!active) begin
            bit_cnt_ff <= 3'h0; // R12
            first_ff   <= 1'b1; // R12
        end else if (rise) begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            rx_ff      <= rx_byte[6:0]; // R5
            if (byte_done) begin
                first_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rw_ff <= 1'b0;
        end else if (byte_done && first_ff) begin
            rw_ff <= is_read; // R11
        end
    end

    // later bytes of a read carry the next address; a byte with bit 7 clear only skips the read
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rd_ff    <= 1'b0;
            reg_wr_ff    <= 1'b0;
            reg_addr_ff  <= 6'h00;
            reg_wdata_ff <= 8'h00;
        end else begin
            reg_rd_ff <= byte_done && is_read && (first_ff || rw_ff); // R8 R11
            reg_wr_ff <= byte_done && !first_ff && !rw_ff; // R9
            if (byte_done && (first_ff || (rw_ff && is_read))) begin
                reg_addr_ff <= rx_byte[shd_pkg::SHD_ADDR_MSB:shd_pkg::SHD_ADDR_LSB]; // R10
            end
            if (byte_done && !first_ff && !rw_ff) begin
                reg_wdata_ff <= rx_byte; // R9
            end
        end
    end

    // read data is taken one cycle after the read strobe, before the next falling edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_wait_ff <= 1'b0;
            tx_ff      <= 8'h00;
        end else begin
            rd_wait_ff <= reg_rd_ff;
            if (!active) begin
                tx_ff <= 8'h00;
            end else if (rd_wait_ff) begin
                tx_ff <= reg_rdata; // R8
            end else if (fall) begin
                tx_ff <= {tx_ff[6:0], 1'b0}; // R5
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            miso_ff    <= 1'b0;
            miso_oe_ff <= 1'b0;
        end else begin
            miso_oe_ff <= active; // R3
            if (!active) begin
                miso_ff <= 1'b0;
            end else if (fall) begin
                miso_ff <= tx_ff[7]; // R7
            end
        end
    end

    assign test_port_bit7_out = miso_ff;
    assign test_port_bit7_oe  = miso_oe_ff;
    assign host_mode          = mode_ff;
    assign reg_addr           = reg_addr_ff;
    assign reg_wdata          = reg_wdata_ff;
    assign reg_wr             = reg_wr_ff;
    assign reg_rd             = reg_rd_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    mode_frozen_a: assert property ((state_ff != shd_pkg::SHD_ST_SETTLE) |=> $stable(state_ff)) // R1
        else $error("interface type changed after detection");
    mode_select_a: assert property ($rose(state_ff == shd_pkg::SHD_ST_SPI)
        |-> $past(!pins.strap_i2c && pins.strap_addr)) // R2
        else $error("SPI chosen with wrong straps");
    miso_fall_a: assert property (active && fall |=> miso_ff == $past(tx_ff[7])) // R7
        else $error("MISO not updated on falling edge");
    miso_hold_a: assert property (active && !fall |=> miso_ff == $past(miso_ff)) // R7
        else $error("MISO moved without a falling edge");
    wdata_msb_a: assert property (byte_done && !first_ff && !rw_ff
        |=> reg_wr_ff && reg_wdata == $past(rx_byte)) // R5
        else $error("write byte not assembled MSB first");
    rd_decode_a: assert property (byte_done && first_ff && is_read
        |=> reg_rd_ff && reg_addr_ff == $past(rx_byte[6:1])) // R11
        else $error("read address not decoded from first byte");
    rd_data_a: assert property (reg_rd_ff ##1 active |=> tx_ff == $past(reg_rdata)) // R8
        else $error("read data not loaded for shifting");
    rd_stop_a: assert property (byte_done && !first_ff && rw_ff && !is_read |=> !reg_rd_ff) // R8
        else $error("terminator byte issued a read");
    wr_only_a: assert property (reg_wr_ff |-> !reg_rd_ff && $past(!rw_ff && !first_ff)) // R9
        else $error("write strobe outside a write transaction");
    addr_bit0_a: assert property (byte_done && first_ff && !is_read
        |=> reg_addr_ff == $past(rx_byte[6:1]) && !reg_rd_ff) // R10
        else $error("write address byte misdecoded");
    cs_clear_a: assert property (!active |=> bit_cnt_ff == 3'h0 && first_ff) // R12
        else $error("chip select high did not clear counters");

    read_seen_c: cover property (reg_rd_ff ##[1:100] reg_rd_ff);
    write_seen_c: cover property (reg_wr_ff ##[1:100] reg_wr_ff);
    abort_seen_c: cover property (active && bit_cnt_ff == 3'h3 ##1 !active);
    stop_seen_c: cover property (byte_done && !first_ff && rw_ff && !is_read);
endmodule

// ### src/shd_pkg.sv
// constants and types shared by the serial host port with interface detection
// Notes on behaviour
// R1 - after reset release, sample the strap pins once and fix the host interface type
// R2 - two-wire strap high picks I2C; else address strap low UART, high SPI
// R3 - in SPI mode act only as slave, serial clock up to 10 Mbit/s; the core needs 3 clk per sck phase, so 3.33 Mbit/s at 20 MHz
// R4 - the host master drives the serial clock and all bytes on MOSI
// R5 - every byte on MOSI and MISO travels most significant bit first
// R6 - master holds MOSI stable at rising edges; device samples on rising edge
// R7 - device changes MISO on falling edges, stable at the next rising edge
// R8 - read: one address byte per read, data trails by a byte, zero byte ends
// R9 - write: one address byte then any number of data bytes; MISO unused
// R10 - address byte: bit 7 read flag, bits 6 to 1 address, bit 0 zero
// R11 - read or write mode and address come from the first byte of a transaction
// R12 - chip select high ends the transaction and clears byte and bit counts
package shd_pkg;

    // host interface type shown on the mode output
    localparam logic [1:0] SHD_MODE_NONE = 2'h0;
    localparam logic [1:0] SHD_MODE_UART = 2'h1;
    localparam logic [1:0] SHD_MODE_SPI  = 2'h2;
    localparam logic [1:0] SHD_MODE_I2C  = 2'h3;

    typedef enum logic [3:0] {
        SHD_ST_SETTLE = 4'h1,
        SHD_ST_SPI    = 4'h2,
        SHD_ST_UART   = 4'h4,
        SHD_ST_I2C    = 4'h8
    } shd_state_type;

    // synchroniser depth and the wait before the straps are trusted
    localparam int         SHD_SYNC_STAGES   = 2;
    localparam logic [1:0] SHD_SETTLE_CYCLES = 2'h3;

    // synchronised pin vector layout and its idle value (chip select high)
    localparam int         SHD_PIN_W    = 5;
    localparam int         SHD_PIN_CS   = 0;
    localparam int         SHD_PIN_SCK  = 1;
    localparam int         SHD_PIN_MOSI = 2;
    localparam int         SHD_PIN_I2C  = 3;
    localparam int         SHD_PIN_ADDR = 4;
    localparam logic [4:0] SHD_PIN_IDLE = 5'h01;

    // address byte layout
    localparam int SHD_BYTE_W   = 8;
    localparam int SHD_ADDR_W   = 6;
    localparam int SHD_RW_BIT   = 7;
    localparam int SHD_ADDR_MSB = 6;
    localparam int SHD_ADDR_LSB = 1;
    localparam logic [2:0] SHD_LAST_BIT = 3'h7;

    // serial clock budget at the core clock rate
    localparam int SHD_CLK_HZ      = 20000000;
    localparam int SHD_SPI_BPS_MAX = 10000000;
    localparam int SHD_SCK_SAMPLES = SHD_CLK_HZ / SHD_SPI_BPS_MAX;

endpackage

// ### src/shd_pins_if.sv
// synchronised host pins passed from the synchroniser to the port core
interface shd_pins_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic strap_i2c;
    logic strap_addr;

    modport sync_side (output cs_n, output sck, output mosi, output strap_i2c,
                       output strap_addr);
    modport core_side (input cs_n, input sck, input mosi, input strap_i2c,
                       input strap_addr);
endinterface

// ### src/shd_pin_sync.sv
// two-flop synchroniser for all host pins read by the port core
module shd_pin_sync #(
    parameter int STAGES = shd_pkg::SHD_SYNC_STAGES
) (
    input  wire logic  clk,
    input  wire logic  reset_n,
    input  wire logic  cs_n_pin,
    input  wire logic  sck_pin,
    input  wire logic  mosi_pin,
    input  wire logic  strap_i2c_pin,
    input  wire logic  strap_addr_pin,
    shd_pins_if.sync_side pins
);
    logic [shd_pkg::SHD_PIN_W-1:0] stage_ff [STAGES];
    logic [shd_pkg::SHD_PIN_W-1:0] raw;

    assign raw = {strap_addr_pin, strap_i2c_pin, mosi_pin, sck_pin, cs_n_pin};

    genvar g;
    generate
        for (g = 0; g < STAGES; g++) begin : g_stage
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    stage_ff[g] <= shd_pkg::SHD_PIN_IDLE;
                end else if (g == 0) begin
                    stage_ff[g] <= raw;
                end else begin
                    stage_ff[g] <= stage_ff[(g == 0) ? 0 : g-1];
                end
            end
        end
    endgenerate

    assign pins.cs_n       = stage_ff[STAGES-1][shd_pkg::SHD_PIN_CS];
    assign pins.sck        = stage_ff[STAGES-1][shd_pkg::SHD_PIN_SCK];
    assign pins.mosi       = stage_ff[STAGES-1][shd_pkg::SHD_PIN_MOSI];
    assign pins.strap_i2c  = stage_ff[STAGES-1][shd_pkg::SHD_PIN_I2C];
    assign pins.strap_addr = stage_ff[STAGES-1][shd_pkg::SHD_PIN_ADDR];
endmodule

// ### testbench/shd_host_model.sv
// behavioural spi master standing in for the host microcontroller
module shd_host_model (
    input  wire logic clk,
    input  wire logic miso,
    output logic      cs_n,
    output logic      sck,
    output logic      mosi
);
    timeunit 1ns;
    timeprecision 1ns;

    // clk per serial clock phase, just above the 3 clk floor of the core
    localparam int HALF = 5;

    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        mosi = 1'b1;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask

    // chip select frames one transaction; raising it aborts any partial byte
    task automatic select(input logic on);
        wait_n(HALF);
        cs_n = ~on;
        mosi = ~mosi;
        wait_n(HALF);
    endtask

    // mode 0 shift, most significant bit first; the master owns the clock
    task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--) begin
            mosi = tx[i];
            wait_n(HALF);
            sck = 1'b1;
            rx[i] = miso;
            wait_n(HALF);
            sck = 1'b0;
        end
    endtask
endmodule

// ### testbench/tb_top.sv
// self-checking bench for the host port: strap detection and spi register access
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       strap_i2c = 1'b0;
    logic       address_select_strap = 1'b1;
    logic       cs_n;
    logic       sck;
    logic       mosi;
    logic       miso_pin;
    logic       miso_idle = 1'b0;
    logic       bit7_out;
    logic       bit7_oe;
    logic [1:0] host_mode;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata = 8'h00;
    logic       rd_hold = 1'b0;
    logic [7:0] mem [64];
    logic [7:0] exp_mem [64];
    logic [13:0] wq [$];
    logic [7:0] rxq [$];
    logic [7:0] tx [$];
    logic [5:0] addrs [$];
    logic [5:0] rdq [$];
    logic [14:0] exp_w;
    logic [6:0] exp_r;
    logic [7:0] b;
    logic [5:0] a;
    int         n_errors = 0;
    int         samples_checked = 0;
    int         seed = 16390;

    always #25 clk = ~clk;

    // a released miso line shows no stale value
    always @(posedge clk) miso_idle <= ~miso_idle;
    assign miso_pin = bit7_oe ? bit7_out : miso_idle;

    shd_host_model u_host (.clk(clk), .miso(miso_pin), .cs_n(cs_n), .sck(sck), .mosi(mosi));

    spi_host_slave_with_detect u_dut (
        .clk                  (clk),
        .reset_n              (reset_n),
        .strap_i2c            (strap_i2c),
        .address_select_strap (address_select_strap),
        .sda_in               (cs_n),
        .test_port_bit5_in    (sck),
        .test_port_bit6_in    (mosi),
        .test_port_bit7_in    (miso_pin),
        .test_port_bit7_out   (bit7_out),
        .test_port_bit7_oe    (bit7_oe),
        .host_mode            (host_mode),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_wr               (reg_wr),
        .reg_rd               (reg_rd),
        .reg_rdata            (reg_rdata)
    );

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict;
        if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // register file behind the port; read data held through the cycle after the strobe
    always @(negedge clk) begin
        rd_hold <= reg_rd;
        if (reg_rd === 1'b1) reg_rdata <= mem[reg_addr];
        else if (rd_hold !== 1'b1) reg_rdata <= 8'($random(seed));
    end

    always @(posedge clk) begin
        if (reg_wr === 1'b1) begin
            mem[reg_addr] <= reg_wdata;
            exp_w = (wq.size() > 0) ? {1'b1, wq.pop_front()} : 15'h0;
            check({1'b1, reg_addr, reg_wdata}, exp_w);
        end
        if (reg_rd === 1'b1) begin
            exp_r = (rdq.size() > 0) ? {1'b1, rdq.pop_front()} : 7'h00;
            check({1'b1, reg_addr}, exp_r);
        end
    end

    task automatic do_reset(input logic i2c, input logic addr_lvl);
        @(negedge clk);
        reset_n = 1'b0;
        strap_i2c = i2c;
        address_select_strap = addr_lvl;
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask

    task automatic frame(input logic exp_oe);
        u_host.select(1'b1);
        check(bit7_oe, exp_oe);
        rxq = {};
        foreach (tx[i]) begin
            u_host.shift(tx[i], 8, b);
            rxq.push_back(b);
        end
        u_host.select(1'b0);
        check(bit7_oe, 1'b0);
    endtask

    task automatic wait_writes;
        int n;
        n = 0;
        while (wq.size() > 0 && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (wq.size() > 0) begin
            n_errors++;
            give_verdict();
        end
    endtask

    initial begin
        repeat (50000) @(posedge clk);
        n_errors++;
        give_verdict();
    end

    initial begin
        // every strap combination; outside spi mode the serial pins are ignored
        for (int m = 0; m < 4; m++) begin
            do_reset(m[1], m[0]);
            check(host_mode, m[1] ? shd_pkg::SHD_MODE_I2C : m[0] ? shd_pkg::SHD_MODE_SPI
                : shd_pkg::SHD_MODE_UART);
            if (m != 1) begin
                tx = {8'h04, 8'h77};
                frame(1'b0);
            end
        end
        do_reset(1'b0, 1'b1);
        // writes at both address ends and random ones, several data bytes each
        for (int k = 0; k < 4; k++) begin
            a = (k == 0) ? 6'h00 : (k == 1) ? 6'h3F : 6'($random(seed));
            addrs.push_back(a);
            tx = {};
            tx.push_back({1'b0, a, 1'b0});
            for (int d = 0; d < 3; d++) begin
                b = 8'($random(seed));
                tx.push_back(b);
                wq.push_back({a, b});
                exp_mem[a] = b;
            end
            frame(1'b1);
            wait_writes();
            foreach (rxq[i]) check(rxq[i], 8'h00);
        end
        // chained reads closed by a zero byte; data trails the address by one byte
        tx = {};
        foreach (addrs[i]) begin
            tx.push_back({1'b1, addrs[i], 1'b0});
            rdq.push_back(addrs[i]);
        end
        tx.push_back(8'h00);
        frame(1'b1);
        foreach (addrs[i]) check(rxq[i + 1], exp_mem[addrs[i]]);
        check(16'(rdq.size()), 16'h0000);
        // abort in mid byte, then a fresh frame must start from its address byte
        u_host.select(1'b1);
        u_host.shift(8'h2A, 8, b);
        u_host.shift(8'hA5, 4, b);
        u_host.select(1'b0);
        tx = {8'h2A, 8'h5C};
        wq.push_back({6'h15, 8'h5C});
        exp_mem[6'h15] = 8'h5C;
        frame(1'b1);
        wait_writes();
        tx = {8'hAA, 8'h00};
        rdq.push_back(6'h15);
        frame(1'b1);
        check(rxq[1], exp_mem[6'h15]);
        check(16'(rdq.size()), 16'h0000);
        give_verdict();
    end
endmodule
